// [verilog/ring_beacon_defs.svh]
/*
 * address map, field positions, reset values and timing constants of the
 * ring beacon control block; assumes a 12-bit byte address on the register bus.
 */
`ifndef RING_BEACON_DEFS_SVH
`define RING_BEACON_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_SEND_CFG 12'h604
`define OFS_IP 12'h608
`define OFS_CTRL 12'h610
`define OFS_PERIOD 12'h614
`define OFS_DELAY 12'h618
`define OFS_WINDOW 12'h61C
`define OFS_STATUS 12'h630
`define OFS_SEQ 12'h634

// ****************************************
// fields
// ****************************************
`define CFG_UNICAST 31
`define CFG_METHOD_HI 1
`define CFG_MASK 32'h80000003
`define METHOD_SEQ 2'h1
`define CTRL_ASSIST 0
`define CTRL_TXEN 1
`define CTRL_BACKUP 2
`define CTRL_SEQCLR 3
`define CTRL_MASK 8'h0F
`define PORT_1 2'h1
`define PORT_2 2'h2
`define PORT_BOTH 2'h3

// ****************************************
// reset values and timing
// ****************************************
`define RST_PERIOD 32'h00000190
`define RST_DELAY 22'h0007A8
`define RST_WINDOW 22'h001770
`define US_NS 1000
`define CLK_NS 100
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/ring_beacon_pkg.sv]
/*
 * state types of the ring beacon control block; assumes nothing.
 */
package ring_beacon_pkg;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_WAIT = 2'h1,
		TX_SEND1 = 2'h2,
		TX_SEND2 = 2'h3
	} tx_state_type;

	typedef enum logic [1:0] {
		MON_IDLE = 2'h0,
		MON_FIRST = 2'h1,
		MON_DELAY = 2'h2,
		MON_ACTIVE = 2'h3
	} mon_state_type;

endpackage

// [verilog/us_tick.sv]
/*
 * microsecond tick generator; assumes mclk runs at the rate that CYCLES was
 * derived for.
 */
`timescale 1ns/10ps
module us_tick #(
	parameter int CYCLES = 10
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// tick
	output logic tick
);
	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	always_comb
	begin
		tick_d = (cnt_q == LAST);
		cnt_d = tick_d ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// [verilog/backup_monitor.sv]
/*
 * backup supervisor monitor: watches beacon loss pulses of both ring ports and
 * raises active after a loss on each port within the window and the programmed delay; assumes loss
 * pulses are one cycle long and already on mclk.
 */
`timescale 1ns/10ps
`include "ring_beacon_defs.svh"
module backup_monitor (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// control
	input wire logic us_tick,
	input wire logic enable,
	input wire logic [21:0] delay_us,
	input wire logic [21:0] window_us,
	// ring port loss pulses
	input wire logic [1:0] loss,
	// result
	output logic active,
	output ring_beacon_pkg::mon_state_type mon_state
);
	ring_beacon_pkg::mon_state_type state_q, state_d;
	logic [21:0] cnt_q, cnt_d;
	logic first_q, first_d;
	logic active_q, active_d;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		first_d = first_q;
		if (!enable)
		begin
			state_d = ring_beacon_pkg::MON_IDLE;
			cnt_d = '0;
		end
		else
		begin
			case (state_q)
				ring_beacon_pkg::MON_IDLE:
				begin
					cnt_d = '0;
					if (loss == `PORT_BOTH)
						state_d = ring_beacon_pkg::MON_DELAY;
					else if (|loss)
					begin
						state_d = ring_beacon_pkg::MON_FIRST;
						first_d = loss[1];
					end
				end
				ring_beacon_pkg::MON_FIRST:
				begin
					if (loss[!first_q])
					begin
						state_d = ring_beacon_pkg::MON_DELAY;
						cnt_d = '0;
					end
					else if (window_us != '0 && us_tick)
					begin
						if (cnt_q + 22'h1 >= window_us)
							state_d = ring_beacon_pkg::MON_IDLE;
						else
							cnt_d = cnt_q + 22'h1;
					end
				end
				ring_beacon_pkg::MON_DELAY:
				begin
					if (delay_us == '0)
						state_d = ring_beacon_pkg::MON_ACTIVE;
					else if (us_tick)
					begin
						if (cnt_q + 22'h1 >= delay_us)
							state_d = ring_beacon_pkg::MON_ACTIVE;
						else
							cnt_d = cnt_q + 22'h1;
					end
				end
				ring_beacon_pkg::MON_ACTIVE: state_d = ring_beacon_pkg::MON_ACTIVE;
				default: state_d = ring_beacon_pkg::MON_IDLE;
			endcase
		end
		active_d = (state_d == ring_beacon_pkg::MON_ACTIVE);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ring_beacon_pkg::MON_IDLE;
			cnt_q <= '0;
			first_q <= 1'b0;
			active_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			first_q <= first_d;
			active_q <= active_d;
		end
	end

	assign active = active_q;
	assign mon_state = state_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_backup_off;
		!enable |=> !active_q;
	endproperty
	a_backup_off: assert property (p_backup_off) else $error("active without backup enable");

	property p_active_cause;
		$rose(active_q) |-> $past(state_q) == ring_beacon_pkg::MON_DELAY;
	endproperty
	a_active_cause: assert property (p_active_cause) else $error("active not after delay");

	property p_window_zero;
		state_q == ring_beacon_pkg::MON_FIRST && window_us == '0 && enable && loss == 2'h0
			|=> state_q == ring_beacon_pkg::MON_FIRST;
	endproperty
	a_window_zero: assert property (p_window_zero) else $error("zero window expired");
endmodule

// [verilog/ring_beacon_control.sv]
/*
 * ring beacon control: AXI4-Lite register file, beacon scheduler with
 * multicast or per-port unicast sends, sequence identifier and backup
 * supervisor start; assumes a frame builder that takes beacon_req with
 * beacon_ack on mclk and loss pins that are asynchronous.
 */
`timescale 1ns/10ps
`include "ring_beacon_defs.svh"
module ring_beacon_control #(
	parameter int US_CYCLES = `US_NS / `CLK_NS,
	parameter int SEQ_W = 32
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [11:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [11:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// ring port beacon loss pins
	input wire logic [1:0] port_loss,
	// beacon frame request
	output logic beacon_req,
	input wire logic beacon_ack,
	output logic [1:0] beacon_ports,
	output logic beacon_unicast,
	output logic [31:0] beacon_ip_value,
	output logic [SEQ_W-1:0] beacon_seq_id,
	output logic [31:0] beacon_period_us,
	// node status
	output logic supervisor_active,
	output logic ring_hw_assist_enable
);
	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic [11:0] word_of(input logic [11:0] a);
		return {a[11:2], 2'h0};
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		case (word_of(a))
			`OFS_SEND_CFG, `OFS_IP, `OFS_CTRL, `OFS_PERIOD, `OFS_DELAY,
			`OFS_WINDOW, `OFS_STATUS, `OFS_SEQ: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, rd_word;
	logic wr_fire;

	always_comb
	begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d = w_hold_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (awvalid && awready_q)
		begin
			aw_hold_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready_q)
		begin
			w_hold_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
		if (wr_fire)
		begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rdata_d = rd_word;
			rresp_d = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid_q && rready)
			rvalid_d = 1'b0;
		awready_d = !aw_hold_d;
		wready_d = !w_hold_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_hold_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RESP_OKAY;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			aw_addr_q <= aw_addr_d;
			w_hold_q <= w_hold_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] cfg_q, cfg_d, ip_q, ip_d, period_q, period_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [21:0] delay_q, delay_d, window_q, window_d;
	logic tx_used_q, tx_used_d;
	logic backup_active;
	ring_beacon_pkg::mon_state_type mon_state;
	ring_beacon_pkg::tx_state_type tx_q, tx_d;
	logic [SEQ_W-1:0] seq_q, seq_d;

	always_comb
	begin
		cfg_d = cfg_q;
		ip_d = ip_q;
		ctrl_d = ctrl_q;
		period_d = period_q;
		delay_d = delay_q;
		window_d = window_q;
		if (wr_fire)
		begin
			case (word_of(aw_addr_q))
				`OFS_SEND_CFG: cfg_d = merge(cfg_q, wdata_q, wstrb_q) & `CFG_MASK;
				`OFS_IP: ip_d = merge(ip_q, wdata_q, wstrb_q);
				`OFS_CTRL: ctrl_d = 8'(merge({24'h0, ctrl_q}, wdata_q, wstrb_q)) & `CTRL_MASK;
				`OFS_PERIOD: period_d = merge(period_q, wdata_q, wstrb_q);
				`OFS_DELAY: delay_d = 22'(merge({10'h0, delay_q}, wdata_q, wstrb_q));
				`OFS_WINDOW: window_d = 22'(merge({10'h0, window_q}, wdata_q, wstrb_q));
				default: ;
			endcase
		end
		// backup stays disarmed after a transmit-enable run until re-toggled
		if (ctrl_q[`CTRL_TXEN] && !ctrl_d[`CTRL_TXEN])
			tx_used_d = 1'b1;
		else if (!ctrl_d[`CTRL_BACKUP])
			tx_used_d = 1'b0;
		else
			tx_used_d = tx_used_q;
	end

	always_comb
	begin
		rd_word = 32'h0;
		case (word_of(araddr))
			`OFS_SEND_CFG: rd_word = cfg_q;
			`OFS_IP: rd_word = ip_q;
			`OFS_CTRL: rd_word = {24'h0, ctrl_q};
			`OFS_PERIOD: rd_word = period_q;
			`OFS_DELAY: rd_word = {10'h0, delay_q};
			`OFS_WINDOW: rd_word = {10'h0, window_q};
			`OFS_STATUS: rd_word = {26'h0, mon_state, tx_q, backup_active, supervisor_active};
			`OFS_SEQ: rd_word = 32'(seq_q);
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q <= '0;
			ip_q <= '0;
			ctrl_q <= '0;
			period_q <= `RST_PERIOD;
			delay_q <= `RST_DELAY;
			window_q <= `RST_WINDOW;
			tx_used_q <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			ip_q <= ip_d;
			ctrl_q <= ctrl_d;
			period_q <= period_d;
			delay_q <= delay_d;
			window_q <= window_d;
			tx_used_q <= tx_used_d;
		end
	end

	// ****************************************
	// loss pins and backup monitor
	// ****************************************
	logic [1:0] loss_s1_q, loss_s2_q, loss_s3_q;
	logic tick;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			loss_s1_q <= '0;
			loss_s2_q <= '0;
			loss_s3_q <= '0;
		end
		else
		begin
			loss_s1_q <= port_loss;
			loss_s2_q <= loss_s1_q;
			loss_s3_q <= loss_s2_q;
		end
	end

	us_tick #(.CYCLES(US_CYCLES)) u_tick (.mclk(mclk), .nrst(nrst), .tick(tick));

	backup_monitor u_mon (
		.mclk(mclk),
		.nrst(nrst),
		.us_tick(tick),
		.enable(ctrl_q[`CTRL_BACKUP] && !tx_used_q),
		.delay_us(delay_q),
		.window_us(window_q),
		.loss(loss_s2_q & ~loss_s3_q),
		.active(backup_active),
		.mon_state(mon_state)
	);

	// ****************************************
	// beacon scheduler
	// ****************************************
	logic run, split, req_q, req_d, uni_q, uni_d, sup_q, sup_d;
	logic [1:0] ports_q, ports_d;
	logic [31:0] cnt_q, cnt_d;

	always_comb
	begin
		run = ctrl_q[`CTRL_TXEN] || backup_active;
		split = cfg_q[`CFG_UNICAST] && cfg_q[`CFG_METHOD_HI:0] == `METHOD_SEQ;
		tx_d = tx_q;
		cnt_d = cnt_q;
		seq_d = seq_q;
		case (tx_q)
			ring_beacon_pkg::TX_IDLE:
				if (run)
					tx_d = ring_beacon_pkg::TX_SEND1;
			ring_beacon_pkg::TX_WAIT:
				if (tick)
				begin
					if (cnt_q + 32'h1 >= period_q)
					begin
						tx_d = ring_beacon_pkg::TX_SEND1;
						cnt_d = '0;
					end
					else
						cnt_d = cnt_q + 32'h1;
				end
			ring_beacon_pkg::TX_SEND1:
				if (beacon_ack)
				begin
					seq_d = seq_q + SEQ_W'(1);
					tx_d = split ? ring_beacon_pkg::TX_SEND2 : ring_beacon_pkg::TX_WAIT;
				end
			ring_beacon_pkg::TX_SEND2:
				if (beacon_ack)
				begin
					seq_d = seq_q + SEQ_W'(1);
					tx_d = ring_beacon_pkg::TX_WAIT;
				end
			default: tx_d = ring_beacon_pkg::TX_IDLE;
		endcase
		if (!run)
		begin
			tx_d = ring_beacon_pkg::TX_IDLE;
			cnt_d = '0;
		end
		if (ctrl_q[`CTRL_SEQCLR])
			seq_d = '0;
		req_d = tx_d == ring_beacon_pkg::TX_SEND1 || tx_d == ring_beacon_pkg::TX_SEND2;
		uni_d = cfg_q[`CFG_UNICAST];
		if (tx_d == ring_beacon_pkg::TX_SEND2)
			ports_d = `PORT_2;
		else if (split)
			ports_d = `PORT_1;
		else
			ports_d = `PORT_BOTH;
		sup_d = run;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_q <= ring_beacon_pkg::TX_IDLE;
			cnt_q <= '0;
			seq_q <= '0;
			req_q <= 1'b0;
			uni_q <= 1'b0;
			ports_q <= '0;
			sup_q <= 1'b0;
		end
		else
		begin
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			seq_q <= seq_d;
			req_q <= req_d;
			uni_q <= uni_d;
			ports_q <= ports_d;
			sup_q <= sup_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign beacon_req = req_q;
	assign beacon_ports = ports_q;
	assign beacon_unicast = uni_q;
	assign beacon_ip_value = ip_q;
	assign beacon_seq_id = seq_q;
	assign beacon_period_us = period_q;
	assign supervisor_active = sup_q;
	assign ring_hw_assist_enable = ctrl_q[`CTRL_ASSIST];

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	logic beacon_req_q_done, waited_q, waited_d;
	logic [31:0] gap_q, gap_d;
	assign beacon_req_q_done = req_q && beacon_ack && ports_q != `PORT_1 && run;

	// ticks since the last completed beacon, for the period gap check
	always_comb
	begin
		gap_d = beacon_req_q_done ? '0 : gap_q + 32'(tick && !req_q);
		waited_d = beacon_req_q_done || (waited_q && run && !req_q);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			gap_q <= '0;
			waited_q <= 1'b0;
		end
		else
		begin
			gap_q <= gap_d;
			waited_q <= waited_d;
		end
	end

	sequence s_done;
		beacon_req_q_done;
	endsequence

	property p_multicast;
		req_q && !uni_q |-> ports_q == `PORT_BOTH;
	endproperty
	a_multicast: assert property (p_multicast) else $error("multicast not to both ports");

	property p_second_copy;
		req_q && beacon_ack && ports_q == `PORT_1 && run |=> req_q && ports_q == `PORT_2;
	endproperty
	a_second_copy: assert property (p_second_copy) else $error("port 2 copy missing");

	property p_seq_clear;
		ctrl_q[`CTRL_SEQCLR] |=> seq_q == '0;
	endproperty
	a_seq_clear: assert property (p_seq_clear) else $error("sequence not cleared");

	property p_seq_step;
		req_q && beacon_ack && !ctrl_q[`CTRL_SEQCLR] |=> seq_q == $past(seq_q) + SEQ_W'(1);
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("sequence did not step");

	property p_stop;
		!run |=> !req_q && !sup_q;
	endproperty
	a_stop: assert property (p_stop) else $error("beacon while disabled");

	property p_start;
		tx_q == ring_beacon_pkg::TX_IDLE && run |=> req_q;
	endproperty
	a_start: assert property (p_start) else $error("enable did not start beacons");

	property p_spacing;
		s_done |=> !req_q;
	endproperty
	a_spacing: assert property (p_spacing) else $error("request held after final ack");

	property p_period_gap;
		$rose(req_q) && waited_q |-> gap_q >= period_q;
	endproperty
	a_period_gap: assert property (p_period_gap) else $error("beacons closer than period");
endmodule

// [tb/beacon_sink.sv]
/*
 * frame builder model that takes beacon requests and records each one;
 * assumes the block holds a request until beacon_ack on mclk.
 */
`timescale 1ns/10ps
module beacon_sink (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// request from the block
	input wire logic beacon_req,
	input wire logic [1:0] beacon_ports,
	input wire logic beacon_unicast,
	input wire logic [31:0] beacon_ip_value,
	input wire logic [31:0] beacon_seq_id,
	input wire logic slow,
	output logic beacon_ack,
	// record of taken requests
	output int taken,
	output logic [1:0] last_ports,
	output logic last_unicast,
	output logic [31:0] last_ip,
	output logic [31:0] last_seq,
	output int hold_err
);
	int wait_q;
	logic [1:0] ports_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			beacon_ack <= 1'b0;
			wait_q <= 0;
			taken <= 0;
			hold_err <= 0;
			ports_q <= 2'h0;
		end
		else
		begin
			if (beacon_req && beacon_ack)
			begin
				taken <= taken + 1;
				last_ports <= beacon_ports;
				last_unicast <= beacon_unicast;
				last_ip <= beacon_ip_value;
				last_seq <= beacon_seq_id;
			end
			// a stalled request must not change under us
			if (beacon_req && !beacon_ack && wait_q != 0 && beacon_ports !== ports_q)
				hold_err <= hold_err + 1;
			ports_q <= beacon_ports;
			if (beacon_req && !beacon_ack && wait_q >= (slow ? 4 : 0))
			begin
				beacon_ack <= 1'b1;
				wait_q <= 0;
			end
			else
			begin
				beacon_ack <= 1'b0;
				wait_q <= (beacon_req && !beacon_ack) ? wait_q + 1 : 0;
			end
		end
	end
endmodule

// [tb/tb.sv]
/*
 * self-checking bench of ring_beacon_control with a frame builder model;
 * assumes the register map of ring_beacon_defs.svh and a 2-cycle microsecond.
 */
`timescale 1ns/10ps
`include "ring_beacon_defs.svh"
module tb;
	localparam int US_CYC = 2;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] port_loss = 2'h0;
	logic slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, beacon_req, beacon_ack, beacon_unicast;
	logic supervisor_active, ring_hw_assist_enable;
	logic [1:0] bresp, rresp, beacon_ports, last_ports;
	logic [31:0] rdata, beacon_ip_value, beacon_seq_id, beacon_period_us, last_ip, last_seq;
	logic last_unicast;
	int taken, hold_err, c;
	int seen = 0;
	int miscompares = 0;
	int checks = 0;

	always #50 mclk = ~mclk;

	ring_beacon_control #(.US_CYCLES(US_CYC), .SEQ_W(32)) i_dut (.mclk(mclk), .nrst(nrst),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .port_loss(port_loss), .beacon_req(beacon_req),
		.beacon_ack(beacon_ack), .beacon_ports(beacon_ports), .beacon_unicast(beacon_unicast),
		.beacon_ip_value(beacon_ip_value), .beacon_seq_id(beacon_seq_id),
		.beacon_period_us(beacon_period_us), .supervisor_active(supervisor_active),
		.ring_hw_assist_enable(ring_hw_assist_enable));

	beacon_sink i_sink (.mclk(mclk), .nrst(nrst), .beacon_req(beacon_req),
		.beacon_ports(beacon_ports), .beacon_unicast(beacon_unicast),
		.beacon_ip_value(beacon_ip_value), .beacon_seq_id(beacon_seq_id), .slow(slow),
		.beacon_ack(beacon_ack), .taken(taken), .last_ports(last_ports),
		.last_unicast(last_unicast), .last_ip(last_ip), .last_seq(last_seq), .hold_err(hold_err));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = `RESP_OKAY);
		logic aw_done = 1'b0;
		logic w_done = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge mclk);
			if (awvalid && awready)
				aw_done = 1'b1;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				w_done = 1'b1;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		bready <= 1'b1;
		do @(posedge mclk); while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] r = `RESP_OKAY);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge mclk); while (!rvalid);
		rready <= 1'b0;
		chk("rdata", exp, rdata);
		chk("rresp", {30'h0, r}, {30'h0, rresp});
	endtask

	// waits for the next taken beacon, c returns the cycles waited
	task automatic wait_take();
		c = 0;
		while (taken <= seen && c < 2000)
		begin
			@(posedge mclk);
			#1;
			c++;
		end
		chk("beacon taken", 32'h1, {31'h0, taken > seen});
		seen++;
	endtask

	task automatic quiet(input int n);
		repeat (n) @(posedge mclk);
		#1;
		chk("no beacon", seen, taken);
	endtask

	task automatic stop_tx();
		axi_wr(`OFS_CTRL, 32'h00000001);
		repeat (20) @(posedge mclk);
		seen = taken;
	endtask

	task automatic pulse_loss(input int p);
		@(posedge mclk);
		port_loss[p] <= 1'b1;
		repeat (3) @(posedge mclk);
		port_loss[p] <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_reset();
		logic [11:0] a[6] = '{`OFS_SEND_CFG, `OFS_IP, `OFS_CTRL, `OFS_PERIOD, `OFS_DELAY, `OFS_WINDOW};
		logic [31:0] v[6] = '{32'h0, 32'h0, 32'h0, 32'h00000190, 32'h000007A8, 32'h00001770};
		for (int i = 0; i < 6; i++)
			axi_rd(a[i], v[i]);
		chk("assist", 32'h0, {31'h0, ring_hw_assist_enable});
		axi_rd(`OFS_STATUS, 32'h00000000);
		axi_rd(12'h700, 32'h00000000, `RESP_SLVERR);
		axi_wr(12'h700, 32'hFFFFFFFF, `RESP_SLVERR);
		axi_wr(`OFS_SEND_CFG, 32'hFFFFFFFF);
		axi_rd(`OFS_SEND_CFG, 32'h80000003);
		axi_wr(`OFS_SEND_CFG, 32'h00000000);
		$display("test reset done");
	endtask

	task automatic test_multicast();
		axi_wr(`OFS_IP, 32'hC0A80A01);
		axi_wr(`OFS_PERIOD, 32'h00000003);
		axi_wr(`OFS_CTRL, 32'h00000001);
		chk("assist", 32'h1, {31'h0, ring_hw_assist_enable});
		axi_wr(`OFS_CTRL, 32'h00000003);
		wait_take();
		chk("ports", 32'h3, {30'h0, last_ports});
		chk("unicast", 32'h0, {31'h0, last_unicast});
		chk("ip", 32'hC0A80A01, last_ip);
		chk("supervisor", 32'h1, {31'h0, supervisor_active});
		chk("period out", 32'h3, beacon_period_us);
		for (int k = 1; k < 3; k++)
		begin
			wait_take();
			chk("seq", k, last_seq);
			chk("spacing", 32'h1, {31'h0, c >= 3 * US_CYC && c <= 3 * US_CYC + 8});
		end
		stop_tx();
		quiet(40);
		chk("supervisor", 32'h0, {31'h0, supervisor_active});
		$display("test multicast done");
	endtask

	task automatic test_unicast();
		slow <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			axi_wr(`OFS_SEND_CFG, 32'h80000000 | m);
			axi_wr(`OFS_CTRL, 32'h00000003);
			wait_take();
			chk("unicast", 32'h1, {31'h0, last_unicast});
			chk("ports", (m == 1) ? 32'h1 : 32'h3, {30'h0, last_ports});
			if (m == 1)
			begin
				wait_take();
				chk("second port", 32'h2, {30'h0, last_ports});
				chk("pair gap", 32'h1, {31'h0, c <= 8});
			end
			stop_tx();
		end
		slow <= 1'b0;
		chk("held request", 32'h0, hold_err);
		axi_wr(`OFS_SEND_CFG, 32'h00000000);
		$display("test unicast done");
	endtask

	task automatic test_seq_clear();
		axi_wr(`OFS_CTRL, 32'h00000009);
		axi_rd(`OFS_SEQ, 32'h00000000);
		axi_wr(`OFS_SEND_CFG, 32'h00000001);
		axi_wr(`OFS_CTRL, 32'h00000003);
		wait_take();
		chk("seq", 32'h0, last_seq);
		chk("ports", 32'h3, {30'h0, last_ports});
		axi_wr(`OFS_SEND_CFG, 32'h00000000);
		wait_take();
		chk("seq", 32'h1, last_seq);
		stop_tx();
		$display("test sequence clear done");
	endtask

	task automatic backup_try(input logic [31:0] ctl, input logic [31:0] win, input int gap,
		input bit expect_start);
		axi_wr(`OFS_CTRL, 32'h00000001);
		axi_wr(`OFS_WINDOW, win);
		axi_wr(`OFS_DELAY, 32'h00000002);
		axi_wr(`OFS_CTRL, ctl);
		pulse_loss(0);
		repeat (gap) @(posedge mclk);
		pulse_loss(1);
		#1;
		chk("no early beacon", seen, taken);
		if (expect_start)
		begin
			wait_take();
			chk("backup start", 32'h1, {31'h0, c >= 1 && c <= 14});
			chk("supervisor", 32'h1, {31'h0, supervisor_active});
		end
		else
			quiet(60);
		stop_tx();
	endtask

	task automatic test_backup();
		backup_try(32'h00000005, 32'h00000032, 20, 1'b1);
		backup_try(32'h00000005, 32'h00000003, 40, 1'b0);
		backup_try(32'h00000005, 32'h00000000, 300, 1'b1);
		backup_try(32'h00000001, 32'h00000032, 20, 1'b0);
		$display("test backup done");
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		end_sim();
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		test_reset();
		test_multicast();
		test_unicast();
		test_seq_clear();
		test_backup();
		end_sim();
	end
endmodule
